//--- rtl/osc_control.sv
/*
 Oscillator control and status registers behind an APB slave, with
 clock source selection, start-up sequencing and fail-safe fallback.
 Assumes analog ready flags, the oscillator tick, the failure flag and
 the wake-up level come from outside the clock domain; configuration
 and the Timer1 enable are static or on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_control (
   input  wire logic                 clk,              // System clock, 10 MHz
   input  wire logic                 rst_n,            // Async reset, active low
   input  wire logic                 psel,             // APB select
   input  wire logic                 penable,          // APB access phase
   input  wire logic                 pwrite,           // APB write
   input  wire logic [31:0]          paddr,            // APB byte address
   input  wire logic [31:0]          pwdata,           // APB write data
   output logic      [31:0]          prdata,           // APB read data
   output logic                      pready,           // APB ready
   output logic                      pslverr,          // APB error, unmapped
   input  wire logic                 cfgMultEnable,    // Config multiplier enable
   input  wire logic [2:0]           cfgOscMode,       // Config oscillator mode
   input  wire logic                 timer1OscEnable,  // Timer1 oscillator enable
   input  wire logic                 hfStablePin,      // High source within 0.5%
   input  wire logic                 lfReadyPin,       // Low source ready
   input  wire logic                 mfReadyPin,       // Medium source ready
   input  wire logic                 hfLockedPin,      // High source within 2%
   input  wire logic                 hfReadyPin,       // High source ready
   input  wire logic                 multReadyPin,     // Multiplier ready
   input  wire logic                 timer1ReadyPin,   // Timer1 oscillator ready
   input  wire logic                 extOscPin,        // Primary oscillator level
   input  wire logic                 extFailPin,       // Failure monitor flag
   input  wire logic                 wakeUpPin,        // Wake from sleep level
   output logic                      multiplierEnable, // Multiplier on
   output osc_ctrl_pkg::int_src_t    internalSource,   // Internal source, one-hot
   output logic      [3:0]           internalFreq,     // Frequency select code
   output logic                      hfHighRange,      // Code 1110 in use
   output osc_ctrl_pkg::sys_src_t    systemSource,     // System clock source
   output logic signed [5:0]         freqTrim,         // Signed trim
   output logic                      failsafeActive    // Running on fallback
);
   import osc_ctrl_pkg::*;

   // Register hit, one-hot {trim, status, control}; zero is unmapped
   function automatic logic [2:0] regHit(input logic [31:0] a);
      logic [2:0] h;
      h = 3'b000;
      if (a == CTRL_OFFSET) h = 3'b001;
      if (a == STAT_OFFSET) h = 3'b010;
      if (a == TRIM_OFFSET) h = 3'b100;
      return h;
   endfunction : regHit

   // Internal source decode from the frequency select code
   function automatic int_src_t freqSource(input logic [3:0] f);
      int_src_t s;
      s = INT_HF;
      case (f)
         4'h0, 4'h1: s = INT_LF;
         4'h2, 4'h4, 4'h5, 4'h6, 4'h7: s = INT_MF;
         4'h3, 4'h8, 4'h9, 4'hA: s = INT_HF;
         4'hB, 4'hC, 4'hD, 4'hE, 4'hF: s = INT_HF;
         default: s = INT_HF;
      endcase
      return s;
   endfunction : freqSource

   logic [7:0]        ctrl;
   logic [SYNC_W-1:0] syncA;
   logic [SYNC_W-1:0] syncB;
   logic [SYNC_W-1:0] rawIn;
   logic              tickPrev;
   logic              wakePrev;
   logic              wakeRise;
   logic              scsChange;
   logic [1:0]        scsPrev;
   logic              crystalMode;
   logic              setupPhase;
   logic              access;
   logic [2:0]        hitNow;
   logic [7:0]        statusWord;
   clk_state_t        state;
   clk_state_t        next_state;
   osc_timer_if       tmrLink ();

   assign rawIn = {wakeUpPin, extFailPin, extOscPin, timer1ReadyPin,
                   multReadyPin, hfReadyPin, hfLockedPin, mfReadyPin,
                   lfReadyPin, hfStablePin};

   // Two flops per pin; only syncB is read by logic
   generate
      for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               syncA[i] <= 1'b0;
               syncB[i] <= 1'b0;
            end else begin
               syncA[i] <= rawIn[i];
               syncB[i] <= syncA[i];
            end
         end
      end
   endgenerate

   // Edge history for the oscillator tick, wake-up and clock select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tickPrev <= 1'b0;
         wakePrev <= 1'b0;
         scsPrev  <= CTRL_RESET[CTRL_SCS_LSB +: 2];
      end else begin
         tickPrev <= syncB[7];
         wakePrev <= syncB[9];
         scsPrev  <= ctrl[CTRL_SCS_LSB +: 2];
      end
   end

   assign tmrLink.tick = syncB[7] & ~tickPrev;
   assign wakeRise     = syncB[9] & ~wakePrev;
   assign scsChange    = scsPrev != ctrl[CTRL_SCS_LSB +: 2];
   assign crystalMode  = (cfgOscMode == MODE_LP) || (cfgOscMode == MODE_XT) ||
                         (cfgOscMode == MODE_HS);

   startup_timer u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .tmr   (tmrLink.timer)
   );

   // Bus phases; pready rises in the first access cycle
   assign setupPhase = psel & ~penable;
   assign access     = psel & penable & pready;
   assign hitNow     = regHit(paddr);

   // Status word built from hardware only
   always_comb begin
      statusWord              = 8'h00;
      statusWord[ST_T1_BIT]   = timer1OscEnable ? syncB[6] : 1'b1;
      statusWord[ST_MULT_BIT] = syncB[5];
      statusWord[ST_EXT_BIT]  = state == ST_EXT;
      statusWord[ST_HFR_BIT]  = syncB[4];
      statusWord[ST_HFL_BIT]  = syncB[3];
      statusWord[ST_MFR_BIT]  = syncB[2];
      statusWord[ST_LFR_BIT]  = syncB[1];
      statusWord[ST_HFS_BIT]  = syncB[0];
   end

   // Answer latched at setup so prdata and pready come from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setupPhase) begin
         pready  <= 1'b1;
         pslverr <= hitNow == 3'b000;
         case (hitNow)
            3'b001:  prdata <= {24'h00_0000, ctrl & CTRL_WMASK};
            3'b010:  prdata <= {24'h00_0000, statusWord};
            3'b100:  prdata <= {26'h000_0000, freqTrim};
            default: prdata <= 32'h0000_0000;
         endcase
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Control register; status has no storage so its writes vanish
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (access && pwrite && hitNow == 3'b001) begin
         ctrl <= pwdata[7:0] & CTRL_WMASK;
      end
   end

   // Trim register, passed on as a signed code
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freqTrim <= TRIM_RESET;
      end else if (access && pwrite && hitNow == 3'b100) begin
         freqTrim <= signed'(pwdata[5:0]);
      end
   end

   // Start-up sequencing; wake or a new clock select restarts it
   always_comb begin
      next_state    = state;
      tmrLink.start = 1'b0;
      if (wakeRise || scsChange) begin
         next_state = ST_START;
      end else begin
         case (state)
            ST_START: begin
               if (cfgOscMode == MODE_INTOSC) begin
                  next_state = ST_INT;
               end else if (crystalMode) begin
                  tmrLink.start = 1'b1;
                  next_state    = ST_COUNT;
               end else begin
                  next_state = ST_EXT;
               end
            end
            ST_COUNT: begin
               if (tmrLink.done) next_state = ST_EXT;
            end
            ST_EXT: begin
               if (syncB[8]) next_state = ST_INT;
            end
            ST_INT:   next_state = ST_INT;
            default:  next_state = ST_START;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) state <= ST_START;
      else        state <= next_state;
   end

   // Fail-safe flag; cleared only by a restart of the sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         failsafeActive <= 1'b0;
      end else if (state == ST_EXT && next_state == ST_INT) begin
         failsafeActive <= 1'b1;
      end else if (next_state == ST_START) begin
         failsafeActive <= 1'b0;
      end
   end

   // Multiplier enable; configuration overrides software
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) multiplierEnable <= 1'b0;
      else if (cfgMultEnable) multiplierEnable <= 1'b1;
      else multiplierEnable <= ctrl[CTRL_MULT_BIT];
   end

   // Internal source follows the select code at once, so fallback
   // lands on whatever software prepared beforehand
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         internalSource <= INT_MF;
         internalFreq   <= CTRL_RESET[CTRL_FREQ_LSB +: 4];
         hfHighRange    <= 1'b0;
      end else begin
         internalSource <= freqSource(ctrl[CTRL_FREQ_LSB +: 4]);
         internalFreq   <= ctrl[CTRL_FREQ_LSB +: 4];
         hfHighRange    <= ctrl[CTRL_FREQ_LSB +: 4] == 4'hE;
      end
   end

   // System clock source; primary only once start-up is complete
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         systemSource <= SRC_INTERNAL;
      end else if (ctrl[CTRL_SCS_LSB + 1]) begin
         systemSource <= SRC_INTERNAL;
      end else if (ctrl[CTRL_SCS_LSB]) begin
         systemSource <= SRC_TIMER1;
      end else begin
         systemSource <= (state == ST_EXT) ? SRC_PRIMARY : SRC_INTERNAL;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   multConfig_a: assert property (cfgMultEnable |=> multiplierEnable)
      else $error("multiplier off despite config enable");

   multSoft_a: assert property (!cfgMultEnable |=> multiplierEnable == $past(ctrl[7]))
      else $error("multiplier not following software bit");

   lowSource_a: assert property (ctrl[6:4] == 3'b000 |=> internalSource == INT_LF)
      else $error("low source not selected");

   midSource_a: assert property (ctrl[6:3] == 4'h2 || ctrl[6:3] == 4'h7
      |=> internalSource == INT_MF)
      else $error("medium source not selected");

   dupHigh_a: assert property (ctrl[6:3] == 4'h3 || ctrl[6:3] == 4'hA
      |=> internalSource == INT_HF)
      else $error("duplicate code not on high source");

   highCode_a: assert property (ctrl[6:3] == 4'hE |=> hfHighRange && internalSource == INT_HF)
      else $error("code 1110 not high range");

   bit2Read_a: assert property (setupPhase && paddr == CTRL_OFFSET |=> prdata[2] == 1'b0)
      else $error("control bit 2 read nonzero");

   timer1Ready_a: assert property (setupPhase && paddr == STAT_OFFSET && !timer1OscEnable
      |=> prdata[7])
      else $error("timer1 ready not one when disabled");

   startWait_a: assert property ($rose(state == ST_EXT) && crystalMode && !$past(scsChange)
      |-> $past(tmrLink.done))
      else $error("primary clock taken before count done");

   fallBack_a: assert property (state == ST_EXT && syncB[8] && !wakeRise && !scsChange
      |=> failsafeActive ##1 (ctrl[1:0] != 2'b00 || systemSource == SRC_INTERNAL))
      else $error("no fallback on clock failure");

   statusWrite_a: assert property (access && pwrite && paddr == STAT_OFFSET
      |=> $stable(ctrl) && $stable(freqTrim))
      else $error("status write changed a register");

   trimWrite_a: assert property (access && pwrite && paddr == TRIM_OFFSET
      |=> freqTrim == $past(pwdata[5:0]))
      else $error("trim write lost");

endmodule : osc_control
`default_nettype wire

//--- rtl/startup_timer.sv
/*
 Start-up timer: counts oscillator cycles after a start request and
 pulses done on the last one. Assumes tick is already synchronised
 and one clock wide per oscillator cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module startup_timer (
   input wire logic     clk,   // System clock
   input wire logic     rst_n, // Async reset, active low
   osc_timer_if.timer   tmr    // Start, tick and done
);
   import osc_ctrl_pkg::*;

   logic [OST_W-1:0] count;
   logic             running;

   // A fresh start always wins, so a restart mid-count begins at zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count    <= '0;
         running  <= 1'b0;
         tmr.done <= 1'b0;
      end else if (tmr.start) begin
         count    <= '0;
         running  <= 1'b1;
         tmr.done <= 1'b0;
      end else if (running && tmr.tick) begin
         if (count == OST_W'(OST_COUNT - 1)) begin
            running  <= 1'b0;
            tmr.done <= 1'b1;
         end else begin
            count    <= count + 1'b1;
            tmr.done <= 1'b0;
         end
      end else begin
         tmr.done <= 1'b0;
      end
   end

endmodule : startup_timer
`default_nettype wire

//--- shared/osc_ctrl_pkg.sv
/*
 Constants and types for the oscillator control and status block:
 register offsets, field positions, reset values, source codes and
 the start-up count. Assumes a 32-bit APB slave with word-aligned byte offsets.
*/
package osc_ctrl_pkg;

   // Byte offsets of the three registers
   localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] STAT_OFFSET = 32'h0000_0004;
   localparam logic [31:0] TRIM_OFFSET = 32'h0000_0008;

   // Control field positions
   localparam int CTRL_MULT_BIT = 7;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int CTRL_SCS_LSB  = 0;
   // Writable control bits; bit 2 is absent
   localparam logic [7:0] CTRL_WMASK = 8'hFB;
   localparam logic [7:0] CTRL_RESET = 8'h38;
   localparam logic [5:0] TRIM_RESET = 6'h00;

   // Status bit positions
   localparam int ST_T1_BIT   = 7;
   localparam int ST_MULT_BIT = 6;
   localparam int ST_EXT_BIT  = 5;
   localparam int ST_HFR_BIT  = 4;
   localparam int ST_HFL_BIT  = 3;
   localparam int ST_MFR_BIT  = 2;
   localparam int ST_LFR_BIT  = 1;
   localparam int ST_HFS_BIT  = 0;

   // Configuration oscillator-mode codes
   localparam logic [2:0] MODE_LP     = 3'h0;
   localparam logic [2:0] MODE_XT     = 3'h1;
   localparam logic [2:0] MODE_HS     = 3'h2;
   localparam logic [2:0] MODE_INTOSC = 3'h4;

   // Start-up timer length in oscillator cycles
   localparam int OST_COUNT = 1024;
   localparam int OST_W     = 10;

   // Number of synchronised oscillator inputs
   localparam int SYNC_W = 10;

   typedef enum logic [3:0] {
      ST_START = 4'b0001,
      ST_COUNT = 4'b0010,
      ST_EXT   = 4'b0100,
      ST_INT   = 4'b1000
   } clk_state_t;

   typedef enum logic [2:0] {
      SRC_INTERNAL = 3'b001,
      SRC_TIMER1   = 3'b010,
      SRC_PRIMARY  = 3'b100
   } sys_src_t;

   typedef enum logic [2:0] {
      INT_LF = 3'b001,
      INT_MF = 3'b010,
      INT_HF = 3'b100
   } int_src_t;

endpackage : osc_ctrl_pkg

//--- shared/osc_timer_if.sv
/*
 Link between the control block and its start-up timer.
 Assumes all three signals live on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface osc_timer_if;
   logic start;  // Restart the count
   logic tick;   // One oscillator cycle seen
   logic done;   // Count finished, one-cycle pulse

   modport ctrl  (output start, output tick, input done);
   modport timer (input start, input tick, output done);
endinterface : osc_timer_if
`default_nettype wire

//--- tb/osc_control_test.sv
/*
 Self-checking bench for osc_control: drives APB and pins, queues the
 expected read results and lets a monitor compare them as pready comes.
 Assumes the package constants and a 10 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin errTotal++; $display("MISMATCH at %0t got %h expected %h", $time, (got), (exp)); end end
module osc_control_test;
   import osc_ctrl_pkg::*;
   typedef struct {logic wr; logic [31:0] data; logic err;} exp_t;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = '0, pwdata = '0, prdata;
   logic        pready, pslverr, cfgMultEnable = 1'b0, timer1OscEnable = 1'b0;
   logic [2:0]  cfgOscMode = MODE_INTOSC;
   logic        hfStablePin = 0, lfReadyPin = 0, mfReadyPin = 0, hfLockedPin = 0, hfReadyPin = 0;
   logic        multReadyPin = 0, timer1ReadyPin = 0, extOscPin = 0, extFailPin = 0, wakeUpPin = 0;
   logic        multiplierEnable, hfHighRange, failsafeActive;
   int_src_t    internalSource;
   sys_src_t    systemSource;
   logic [3:0]  internalFreq;
   logic signed [5:0] freqTrim;
   exp_t        expQ[$];
   int          errTotal = 0, numChecks = 0, cycles = 0;
   logic [31:0] seed = 32'h8b28_97f4;

   osc_control osc_control_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfgMultEnable(cfgMultEnable), .cfgOscMode(cfgOscMode), .timer1OscEnable(timer1OscEnable),
      .hfStablePin(hfStablePin), .lfReadyPin(lfReadyPin), .mfReadyPin(mfReadyPin), .hfLockedPin(hfLockedPin),
      .hfReadyPin(hfReadyPin), .multReadyPin(multReadyPin), .timer1ReadyPin(timer1ReadyPin),
      .extOscPin(extOscPin), .extFailPin(extFailPin), .wakeUpPin(wakeUpPin),
      .multiplierEnable(multiplierEnable), .internalSource(internalSource), .internalFreq(internalFreq),
      .hfHighRange(hfHighRange), .systemSource(systemSource), .freqTrim(freqTrim),
      .failsafeActive(failsafeActive));

   // 100 ns period
   always #50 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Control word with bit 2 set, so readback proves it is absent
   function automatic logic [31:0] ctl(input logic m, input logic [3:0] f, input logic [1:0] s);
      return {24'h0000_00, m, f, 1'b1, s};
   endfunction : ctl

   // Expected internal source of a frequency code
   function automatic int_src_t srcOf(input logic [3:0] c);
      if (c[3:1] == 3'h0) return INT_LF;
      if (c == 4'h2 || (c >= 4'h4 && c <= 4'h7)) return INT_MF;
      return INT_HF;
   endfunction : srcOf

   task automatic conclude();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // One APB transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] ed,
                      input logic ee);
      expQ.push_back('{w, ed, ee});
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Only pready or the bench timeout ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0000_0000, 1'b0);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, e, 1'b0);
   endtask : rd

   // One oscillator cycle, long enough for the synchroniser
   task automatic tick();
      extOscPin <= 1'b1;
      repeat (2) @(posedge clk);
      extOscPin <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : tick

   // Monitor: takes the oldest note at each completed transfer
   always @(posedge clk) begin
      exp_t e;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && expQ.size() > 0) begin
         e = expQ.pop_front();
         `CHK(pslverr, e.err)
         if (!e.wr) `CHK(prdata, e.data)
      end
   end

   // Hang guard, well above the roughly 4400 cycles of the run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         conclude();
      end
   end

   initial begin
      int i, n;
      logic [31:0] r;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(CTRL_OFFSET, 32'h0000_0038);
      rd(TRIM_OFFSET, 32'h0000_0000);
      `CHK(internalSource, INT_MF)
      `CHK(systemSource, SRC_INTERNAL)
      // Every frequency code, with the absent bit written as one
      for (i = 0; i < 16; i++) begin
         wr(CTRL_OFFSET, ctl(1'b0, i[3:0], 2'b10));
         rd(CTRL_OFFSET, ctl(1'b0, i[3:0], 2'b10) & 32'h0000_00FB);
         `CHK(internalFreq, i[3:0])
         `CHK(internalSource, srcOf(i[3:0]))
         `CHK(hfHighRange, (i == 14))
      end
      $display("test frequency codes done");
      for (i = 0; i < 4; i++) begin
         cfgMultEnable <= i[1];
         wr(CTRL_OFFSET, ctl(i[0], 4'h7, 2'b10));
         // Output follows the control write one edge later; skip its launch edge
         repeat (2) @(posedge clk);
         `CHK(multiplierEnable, (i[1] | i[0]))
      end
      cfgMultEnable <= 1'b0;
      $display("test multiplier done");
      // External clock mode needs no start-up count
      cfgOscMode <= 3'h3;
      for (i = 0; i < 4; i++) begin
         r = (i == 3) ? 32'h0 : i + 1;
         wr(CTRL_OFFSET, ctl(1'b0, 4'h7, r[1:0]));
         repeat (4) @(posedge clk);
         `CHK(systemSource, (r[1] ? SRC_INTERNAL : (r[0] ? SRC_TIMER1 : SRC_PRIMARY)))
      end
      $display("test clock select done");
      for (i = 0; i < 8; i++) begin
         r = rnd();
         {hfStablePin, lfReadyPin, mfReadyPin, hfLockedPin} <= r[7:4];
         {hfReadyPin, multReadyPin, timer1ReadyPin, timer1OscEnable} <= r[3:0];
         repeat (4) @(posedge clk);
         wr(STAT_OFFSET, rnd());
         rd(STAT_OFFSET, {24'h0000_00, (r[0] ? r[1] : 1'b1), r[2], 1'b1, r[3], r[4], r[5], r[6], r[7]});
      end
      rd(CTRL_OFFSET, ctl(1'b0, 4'h7, 2'b00) & 32'h0000_00FB);
      $display("test status done");
      for (i = 0; i < 6; i++) begin
         r = (i == 0) ? 32'h0000_001F : ((i == 1) ? 32'h0000_0020 : rnd());
         wr(TRIM_OFFSET, r);
         rd(TRIM_OFFSET, r & 32'h0000_003F);
         `CHK(freqTrim, r[5:0])
      end
      apb(1'b0, 32'h0000_000C, 32'h0000_0000, 32'h0000_0000, 1'b1);
      apb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
      rd(CTRL_OFFSET, ctl(1'b0, 4'h7, 2'b00) & 32'h0000_00FB);
      $display("test trim and unmapped done");
      // Crystal start: 1023 cycles must not switch, the 1024th must
      wr(CTRL_OFFSET, ctl(1'b0, 4'hF, 2'b10));
      cfgOscMode <= MODE_XT;
      wr(CTRL_OFFSET, ctl(1'b0, 4'hF, 2'b00));
      repeat (1023) tick();
      repeat (10) @(posedge clk);
      `CHK(systemSource, SRC_INTERNAL)
      tick();
      for (n = 0; n < 20 && systemSource !== SRC_PRIMARY; n++) @(posedge clk);
      `CHK(systemSource, SRC_PRIMARY)
      // Failure falls back to the preselected internal source
      extFailPin <= 1'b1;
      for (n = 0; n < 10 && failsafeActive !== 1'b1; n++) @(posedge clk);
      `CHK(failsafeActive, 1'b1)
      // Source register follows the state one edge after the flag
      @(posedge clk);
      `CHK(systemSource, SRC_INTERNAL)
      `CHK(internalSource, INT_HF)
      extFailPin <= 1'b0;
      wr(CTRL_OFFSET, ctl(1'b0, 4'hF, 2'b10));
      repeat (4) @(posedge clk);
      `CHK(failsafeActive, 1'b0)
      $display("test start-up and fallback done");
      // Wake edge clears the fallback; a mid-run reset restores defaults
      cfgOscMode <= 3'h3;
      wr(CTRL_OFFSET, ctl(1'b0, 4'hF, 2'b00));
      extFailPin <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(failsafeActive, 1'b1)
      extFailPin <= 1'b0;
      wakeUpPin  <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(failsafeActive, 1'b0)
      `CHK(systemSource, SRC_PRIMARY)
      wakeUpPin <= 1'b0;
      rst_n     <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(CTRL_OFFSET, 32'h0000_0038);
      rd(TRIM_OFFSET, 32'h0000_0000);
      `CHK(internalSource, INT_MF)
      $display("test wake and reset done");
      conclude();
   end
endmodule : osc_control_test
`default_nettype wire
